//--- logic/fiec_pkg.sv
// Constants and shared types for the fast input edge capture block
// What this block does
// - Edge code picks rising, falling, or alternating
// - Reset and unwritten mode capture rising only
// - Report distance between last two captures
// - Rising-only mode: status bit one, rise-to-rise
// - Falling-only mode: status bit zero, fall-to-fall
// - Alternating, bit one: falling to rising
// - Alternating, bit zero: rising to falling
// - Latch software position apart from hardware latch
// - Distance also readable in feedback units
// - Captured position also readable in feedback units
package fiec_pkg;

  // Bus and datapath widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned POS_W  = 32;

  // Register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_EDGE_MODE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DIST_PROG  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DIST_FB    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAP_PROG   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CAP_FB     = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_HW_LATCH   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h24;

  // Edge-select codes
  localparam logic [1:0] MODE_RISE     = 2'h0;
  localparam logic [1:0] MODE_FALL     = 2'h1;
  localparam logic [1:0] MODE_ALT_RISE = 2'h2;
  localparam logic [1:0] MODE_ALT_FALL = 2'h3;
  localparam logic [1:0] MODE_RESET    = MODE_RISE;

  // Field positions
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned STAT_RISE_BIT   = 0;
  localparam int unsigned STAT_VALID_BIT  = 1;
  localparam int unsigned STAT_ENABLE_BIT = 2;
  localparam int unsigned IRQ_CAP_BIT     = 0;
  localparam int unsigned IRQ_DIST_BIT    = 1;
  localparam int unsigned IRQ_W           = 2;

  // Reset values
  localparam logic              ENABLE_RESET   = 1'b0;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RESET = 2'h0;
  localparam logic [POS_W-1:0]  POS_RESET      = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RDATA_IDLE     = 32'h0000_0000;

  // Count of captures held; two means a distance exists
  localparam logic [1:0] NCAP_FULL = 2'h2;

  // Which edge the alternating sequencer waits for next
  typedef enum logic {
    EXP_RISE,
    EXP_FALL
  } fiec_expect_t;

endpackage

//--- logic/fiec_edge_if.sv
// Carrier between the capture core and its edge qualifier
interface fiec_edge_if;
  import fiec_pkg::*;

  logic [1:0] mode;     // Selected edge code
  logic       enable;   // Capture armed by software
  logic       restart;  // Pulse: restart alternating order
  logic       cap;      // Pulse: qualified capture edge
  logic       cap_rise; // Edge kind of that capture

  modport core (
    output mode,
    output enable,
    output restart,
    input  cap,
    input  cap_rise
  );

  // Qualifier side; the plain word for this side is reserved by the language
  modport qual (
    input  mode,
    input  enable,
    input  restart,
    output cap,
    output cap_rise
  );
endinterface

//--- logic/fiec_edge.sv
// Fast input synchroniser, edge detector and edge-mode qualifier
module fiec_edge
  import fiec_pkg::*;
(
  input  wire logic sys_clk,  // Module clock
  input  wire logic rst_n,    // Synchronous reset, active low
  input  wire logic fast_in,  // Raw fast input line
  fiec_edge_if.qual eif       // Link to the capture core
);

  // All state of the qualifier
  typedef struct packed {
    logic         sync1;    // First synchroniser stage
    logic         sync2;    // Second synchroniser stage
    logic         prev;     // Previous synchronised sample
    fiec_expect_t expect_e; // Next edge in alternating modes
    logic         cap;      // Registered capture pulse
    logic         cap_rise; // Registered edge kind
  } fiec_edge_st_t;

  fiec_edge_st_t s_q;  // Current state
  fiec_edge_st_t s_d;  // Next state

  logic rise;  // Rising edge seen this cycle
  logic fall;  // Falling edge seen this cycle
  logic take;  // Edge accepted by the mode

  // Next-state logic
  always_comb begin
    s_d          = s_q;
    // Stage one feeds stage two only; metastability stays contained
    s_d.sync1    = fast_in;
    s_d.sync2    = s_q.sync1;
    s_d.prev     = s_q.sync2;
    // Compare successive settled samples
    rise         = s_q.sync2 & ~s_q.prev;
    fall         = ~s_q.sync2 & s_q.prev;
    take         = 1'b0;
    s_d.cap      = 1'b0;
    s_d.cap_rise = s_q.cap_rise;
    case (eif.mode)
      // Rising only, also the reset choice
      MODE_RISE: begin
        take = rise;
      end
      // Falling only
      MODE_FALL: begin
        take = fall;
      end
      // Alternating modes follow the expected edge
      MODE_ALT_RISE, MODE_ALT_FALL: begin
        take = (s_q.expect_e == EXP_RISE) ? rise : fall;
      end
      default: begin
        take = 1'b0;
      end
    endcase
    // Captures only while armed by software
    if (eif.enable && take) begin
      s_d.cap      = 1'b1;
      s_d.cap_rise = rise;
      s_d.expect_e = rise ? EXP_FALL : EXP_RISE;
    end
    // Mode write or arming restarts the alternating order
    if (eif.restart) begin
      s_d.expect_e = (eif.mode == MODE_ALT_FALL) ? EXP_FALL : EXP_RISE;
    end
    if (!rst_n) begin
      s_d.sync1    = 1'b0;
      s_d.sync2    = 1'b0;
      s_d.prev     = 1'b0;
      s_d.expect_e = EXP_RISE;
      s_d.cap      = 1'b0;
      s_d.cap_rise = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  assign eif.cap      = s_q.cap;
  assign eif.cap_rise = s_q.cap_rise;

endmodule

//--- logic/fiec_core.sv
// Fast input edge capture: registers, position latches, distances, interrupt
//
// The register addresses and the address-and-strobe port are this design's own decisions.
module fiec_core
  import fiec_pkg::*;
(
  input  wire logic              sys_clk,   // Module clock, 20 MHz
  input  wire logic              rst_n,     // Synchronous reset, active low
  input  wire logic              fast_in,   // Axis fast input line
  input  wire logic [POS_W-1:0]  pos_prog,  // Software position, programming units
  input  wire logic [POS_W-1:0]  pos_fb,    // Software position, feedback units
  input  wire logic [POS_W-1:0]  pos_hw,    // Raw hardware position counter
  input  wire logic [ADDR_W-1:0] addr,      // Register byte address
  input  wire logic [DATA_W-1:0] wdata,     // Write data
  input  wire logic              wr,        // Write strobe, one cycle
  input  wire logic              rd,        // Read strobe, one cycle
  output logic      [DATA_W-1:0] rdata,     // Read data, cycle after rd
  output logic                   irq        // Level interrupt
);

  // All state of the core
  typedef struct packed {
    logic [1:0]        mode;       // Edge-select code
    logic              enable;     // Capture armed
    logic              restart;    // Restart pulse to qualifier
    logic              last_rise;  // Kind of the latest capture
    logic [1:0]        ncap;       // Captures seen, saturating
    logic [POS_W-1:0]  cap_prog;   // Latched software position
    logic [POS_W-1:0]  cap_fb;     // Same in feedback units
    logic [POS_W-1:0]  hw_latch;   // Latched raw hardware position
    logic [POS_W-1:0]  dist_prog;  // Distance, programming units
    logic [POS_W-1:0]  dist_fb;    // Distance, feedback units
    logic [IRQ_W-1:0]  irq_st;     // Sticky event bits
    logic [IRQ_W-1:0]  irq_mask;   // Interrupt enables
    logic [DATA_W-1:0] rdata;      // Read data register
  } fiec_core_st_t;

  fiec_core_st_t s_q;  // Current state
  fiec_core_st_t s_d;  // Next state

  fiec_edge_if eif ();  // Link to the edge qualifier

  logic [IRQ_W-1:0]  ev;       // Events this cycle
  logic              ev_dist;  // A fresh distance is produced
  logic [DATA_W-1:0] rmux;     // Selected read value

  // Edge detection and qualification
  fiec_edge u_edge (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .fast_in (fast_in),
    .eif     (eif)
  );

  assign eif.mode    = s_q.mode;
  assign eif.enable  = s_q.enable;
  assign eif.restart = s_q.restart;

  // Next-state logic
  always_comb begin
    s_d         = s_q;
    s_d.restart = 1'b0;
    ev          = '0;
    ev_dist     = 1'b0;
    rmux        = RDATA_IDLE;

    // Capture: latch position and measure from the previous capture
    if (eif.cap) begin
      s_d.cap_prog  = pos_prog;
      s_d.cap_fb    = pos_fb;
      // Raw latch kept apart so software position is undisturbed
      s_d.hw_latch  = pos_hw;
      s_d.last_rise = eif.cap_rise;
      // Wraparound subtraction keeps signed distance across rollover
      s_d.dist_prog = pos_prog - s_q.cap_prog;
      s_d.dist_fb   = pos_fb - s_q.cap_fb;
      if (s_q.ncap != NCAP_FULL) begin
        s_d.ncap = s_q.ncap + 2'h1;
      end
      ev[IRQ_CAP_BIT] = 1'b1;
      // First capture has no predecessor, so no distance yet
      ev_dist          = (s_q.ncap != 2'h0);
      ev[IRQ_DIST_BIT] = ev_dist;
    end

    // Register writes
    if (wr) begin
      case (addr)
        OFS_EDGE_MODE: begin
          s_d.mode    = wdata[1:0];
          s_d.restart = 1'b1;
          // New edge pairing invalidates the old distance
          s_d.ncap    = 2'h0;
        end
        OFS_CONTROL: begin
          s_d.enable  = wdata[CTRL_ENABLE_BIT];
          s_d.restart = 1'b1;
          if (!wdata[CTRL_ENABLE_BIT]) begin
            s_d.ncap = 2'h0;
          end
        end
        OFS_IRQ_MASK: begin
          s_d.irq_mask = wdata[IRQ_W-1:0];
        end
        default: begin
          // Read-only or unmapped: write ignored
        end
      endcase
    end

    // Read multiplexer
    case (addr)
      OFS_EDGE_MODE:  rmux = {{(DATA_W-2){1'b0}}, s_q.mode};
      OFS_CONTROL:    rmux = {{(DATA_W-1){1'b0}}, s_q.enable};
      OFS_STATUS: begin
        rmux = RDATA_IDLE;
        rmux[STAT_RISE_BIT]   = s_q.last_rise;
        rmux[STAT_VALID_BIT]  = (s_q.ncap == NCAP_FULL);
        rmux[STAT_ENABLE_BIT] = s_q.enable;
      end
      // Value stands until the next capture; the program reads after its call
      OFS_DIST_PROG:  rmux = s_q.dist_prog;
      OFS_DIST_FB:    rmux = s_q.dist_fb;
      OFS_CAP_PROG:   rmux = s_q.cap_prog;
      OFS_CAP_FB:     rmux = s_q.cap_fb;
      OFS_HW_LATCH:   rmux = s_q.hw_latch;
      OFS_IRQ_STATUS: rmux = {{(DATA_W-IRQ_W){1'b0}}, s_q.irq_st};
      OFS_IRQ_MASK:   rmux = {{(DATA_W-IRQ_W){1'b0}}, s_q.irq_mask};
      default:        rmux = RDATA_IDLE;
    endcase

    // Read data valid in the cycle after the strobe only
    s_d.rdata = rd ? rmux : RDATA_IDLE;

    // Sticky events; read clears, but a same-cycle event survives
    if (rd && (addr == OFS_IRQ_STATUS)) begin
      s_d.irq_st = ev;
    end else begin
      s_d.irq_st = s_q.irq_st | ev;
    end

    // Reset values; mode defaults to rising only
    if (!rst_n) begin
      s_d.mode      = MODE_RESET;
      s_d.enable    = ENABLE_RESET;
      s_d.restart   = 1'b1;
      s_d.last_rise = 1'b0;
      s_d.ncap      = 2'h0;
      s_d.cap_prog  = POS_RESET;
      s_d.cap_fb    = POS_RESET;
      s_d.hw_latch  = POS_RESET;
      s_d.dist_prog = POS_RESET;
      s_d.dist_fb   = POS_RESET;
      s_d.irq_st    = '0;
      s_d.irq_mask  = IRQ_MASK_RESET;
      s_d.rdata     = RDATA_IDLE;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    s_q <= s_d;
  end

  // Outputs
  assign rdata = s_q.rdata;
  assign irq   = |(s_q.irq_st & s_q.irq_mask);

endmodule

//--- bench/fiec_core_asserts.sv
// Checker on the top ports of the fast input edge capture block
module fiec_chk
  import fiec_pkg::*;
(
  input wire logic              sys_clk, // Module clock
  input wire logic              rst_n,   // Synchronous reset, active low
  input wire logic              fast_in, // Fast input line
  input wire logic [ADDR_W-1:0] addr,    // Register address
  input wire logic [DATA_W-1:0] wdata,   // Write data
  input wire logic              wr,      // Write strobe
  input wire logic              rd,      // Read strobe
  input wire logic [DATA_W-1:0] rdata,   // Read data
  input wire logic              irq      // Level interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]       mode_q; // Shadow of the edge code
  logic             en_q;   // Shadow of the enable bit
  logic [IRQ_W-1:0] msk_q;  // Shadow of the interrupt mask
  logic             mw_q;   // Edge code written since reset
  logic [2:0]       f_q;    // Copy of the synchroniser and previous sample

  // Shadow registers follow bus writes; the copy chain mirrors the input sync
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_q <= MODE_RESET;
      en_q   <= ENABLE_RESET;
      msk_q  <= IRQ_MASK_RESET;
      mw_q   <= 1'b0;
      f_q    <= 3'h0;
    end else begin
      f_q <= {f_q[1:0], fast_in};
      if (wr && addr == OFS_EDGE_MODE) begin
        mode_q <= wdata[1:0];
        mw_q   <= 1'b1;
      end
      if (wr && addr == OFS_CONTROL) en_q <= wdata[CTRL_ENABLE_BIT];
      if (wr && addr == OFS_IRQ_MASK) msk_q <= wdata[IRQ_W-1:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Edges as the block sees them after synchronising
  sequence s_rise; f_q[1] && !f_q[2]; endsequence
  sequence s_fall; !f_q[1] && f_q[2]; endsequence

  property p_rd_idle; !rd |=> rdata == RDATA_IDLE; endproperty
  property p_unmapped; rd && addr == 8'h30 |=> rdata == RDATA_IDLE; endproperty
  property p_mode_rb; rd && addr == OFS_EDGE_MODE |=> rdata[1:0] == mode_q; endproperty
  property p_mode_dflt;
    rd && addr == OFS_EDGE_MODE && !mw_q |=> rdata[1:0] == MODE_RESET;
  endproperty
  property p_rise_stat;
    rd && addr == OFS_STATUS && mode_q == MODE_RISE |=> !rdata[1] || rdata[0];
  endproperty
  property p_fall_stat;
    rd && addr == OFS_STATUS && mode_q == MODE_FALL |=> !rdata[1] || !rdata[0];
  endproperty
  // Capture must reach the interrupt within three cycles of detection
  property p_cap_rise; (en_q && mode_q == MODE_RISE && msk_q[0]) ##0 s_rise |-> ##[1:3] irq;
  endproperty
  property p_cap_fall; (en_q && mode_q == MODE_FALL && msk_q[0]) ##0 s_fall |-> ##[1:3] irq;
  endproperty
  property p_irq_mask; msk_q == 2'h0 |-> !irq; endproperty
  property p_stat_en; rd && addr == OFS_STATUS |=> rdata[STAT_ENABLE_BIT] == en_q; endproperty
  // Disabled for a while, nothing new may raise the interrupt
  property p_no_cap;
    !en_q && !$past(en_q) && !$past(en_q, 3) && !irq && !wr |=> !irq;
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_mode_rb: assert property (p_mode_rb) else $error("edge code readback wrong");
  a_mode_dflt: assert property (p_mode_dflt) else $error("edge code default wrong");
  a_rise_stat: assert property (p_rise_stat) else $error("rising bit wrong");
  a_fall_stat: assert property (p_fall_stat) else $error("falling bit wrong");
  a_cap_rise: assert property (p_cap_rise) else $error("rising edge missed");
  a_cap_fall: assert property (p_cap_fall) else $error("falling edge missed");
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
  a_stat_en: assert property (p_stat_en) else $error("enable bit wrong");
  a_no_cap: assert property (p_no_cap) else $error("capture while disabled");
endmodule

//--- bench/fiec_axis_model.sv
// Behavioural axis: fast input line and steadily moving position feedback
module fiec_axis_model
  import fiec_pkg::*;
(
  input  wire logic             sys_clk,  // Module clock
  input  wire logic             lvl,      // Commanded input level
  output logic                  fast_in,  // Fast input line
  output logic      [POS_W-1:0] pos_prog, // Position, programming units
  output logic      [POS_W-1:0] pos_fb,   // Position, feedback units
  output logic      [POS_W-1:0] pos_hw    // Raw hardware counter
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [POS_W-1:0] t_q = '0; // Cycles since start

  // Constant speed, so a distance is a fixed multiple of elapsed cycles
  assign pos_prog = t_q * 32'h3;
  assign pos_fb   = t_q * 32'hc;
  assign pos_hw   = t_q * 32'h5;
  // Line follows the command one clock later; single driver, reset hides the start
  always @(posedge sys_clk) begin
    t_q     <= t_q + 32'h1;
    fast_in <= lvl;
  end
endmodule

//--- bench/fiec_core_tb_top.sv
// Testbench top for the fast input edge capture block
module fiec_core_tb_top
  import fiec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              sys_clk = 1'b0;   // 20 MHz clock
  logic              rst_n = 1'b0;     // Reset, active low
  logic [ADDR_W-1:0] addr = '0;        // Bus address
  logic [DATA_W-1:0] wdata = '0;       // Bus write data
  logic              wr = 1'b0;        // Write strobe
  logic              rd = 1'b0;        // Read strobe
  logic              lvl = 1'b0;       // Commanded input level
  logic              fast_in;          // Input line
  logic [POS_W-1:0]  pos_prog;         // Position, programming units
  logic [POS_W-1:0]  pos_fb;           // Position, feedback units
  logic [POS_W-1:0]  pos_hw;           // Raw position
  logic [DATA_W-1:0] rdata;            // Read data
  logic [DATA_W-1:0] last;             // Last value read
  logic              irq;              // Interrupt
  int                err_total = 0;    // Mismatches
  int                comparisons = 0;  // Checks made

  always #25 sys_clk = ~sys_clk;

  fiec_axis_model u_axis (.sys_clk(sys_clk), .lvl(lvl), .fast_in(fast_in),
    .pos_prog(pos_prog), .pos_fb(pos_fb), .pos_hw(pos_hw));
  fiec_core u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .fast_in(fast_in), .pos_prog(pos_prog),
    .pos_fb(pos_fb), .pos_hw(pos_hw), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));

  task automatic chk(input string nm, input logic [DATA_W-1:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe; an empty name skips the check
  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
    @(posedge sys_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    last = rdata;
    if (nm != "") chk(nm, e, rdata);
  endtask
  // Toggle the line n cycles after the previous call
  task automatic tog(input int n);
    repeat (n) @(posedge sys_clk);
    lvl <= ~lvl;
  endtask
  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic t_reset();
    rd_reg(OFS_EDGE_MODE, 32'h0, "edge_mode");
    rd_reg(OFS_CONTROL, 32'h0, "control");
    rd_reg(OFS_IRQ_MASK, 32'h0, "irq_mask");
    wr_reg(OFS_STATUS, 32'h7);
    rd_reg(OFS_STATUS, 32'h0, "status");
    rd_reg(8'h30, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_rise();
    wr_reg(OFS_IRQ_MASK, 32'h3);
    wr_reg(OFS_CONTROL, 32'h1);
    tog(4); tog(10); tog(10);
    settle();
    rd_reg(OFS_STATUS, 32'h7, "status");
    rd_reg(OFS_DIST_PROG, 32'd60, "dist_prog");
    rd_reg(OFS_DIST_FB, 32'd240, "dist_fb");
    rd_reg(OFS_CAP_PROG, 32'h0, "");
    rd_reg(OFS_CAP_FB, last * 4, "cap_fb");
    rd_reg(OFS_HW_LATCH, last / 12 * 5, "hw_latch");
    chk("irq", 32'h1, DATA_W'(irq));
    rd_reg(OFS_IRQ_STATUS, 32'h3, "irq_status");
    chk("irq", 32'h0, DATA_W'(irq));
    $display("test rise done");
  endtask
  task automatic t_fall();
    wr_reg(OFS_EDGE_MODE, 32'h1);
    tog(4); tog(7); tog(9);
    settle();
    rd_reg(OFS_STATUS, 32'h6, "status");
    rd_reg(OFS_DIST_PROG, 32'd48, "dist_prog");
    $display("test fall done");
  endtask
  task automatic t_alt();
    wr_reg(OFS_EDGE_MODE, 32'h2);
    tog(4); tog(6); tog(11);
    settle();
    rd_reg(OFS_STATUS, 32'h7, "status");
    rd_reg(OFS_DIST_PROG, 32'd33, "dist_prog");
    wr_reg(OFS_EDGE_MODE, 32'h2);
    tog(4); tog(7); tog(5);
    settle();
    rd_reg(OFS_STATUS, 32'h6, "status");
    rd_reg(OFS_DIST_PROG, 32'd15, "dist_prog");
    wr_reg(OFS_EDGE_MODE, 32'h3);
    tog(4); tog(4);
    settle();
    rd_reg(OFS_STATUS, 32'h4, "status");
    // Rise after the falling start: 8 settle, 2 read and 6 more edges apart
    tog(6);
    settle();
    rd_reg(OFS_STATUS, 32'h7, "status");
    rd_reg(OFS_DIST_PROG, 32'd48, "dist_prog");
    $display("test alternate done");
  endtask
  task automatic t_mask();
    wr_reg(OFS_EDGE_MODE, 32'h0);
    wr_reg(OFS_IRQ_MASK, 32'h2);
    rd_reg(OFS_IRQ_STATUS, 32'h0, "");
    tog(4); tog(4);
    settle();
    chk("irq", 32'h0, DATA_W'(irq));
    wr_reg(OFS_CONTROL, 32'h0);
    tog(4); tog(4);
    settle();
    rd_reg(OFS_IRQ_STATUS, 32'h1, "irq_status");
    rd_reg(OFS_IRQ_STATUS, 32'h0, "irq_status");
    rd_reg(OFS_STATUS, 32'h1, "status");
    $display("test mask done");
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_rise();
    t_fall();
    t_alt();
    t_mask();
    summarize();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    summarize();
  end
endmodule

bind fiec_core fiec_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .fast_in(fast_in),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
